/* pwmrf_pkg.sv */
// Package for the recoverable-fault and write-guard block of the modulator.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses in the low 8 bits.
package pwmrf_pkg;
	localparam int ADDR_W = 8;

	// Register byte offsets
	localparam logic [7:0] OFF_CHAN_ENABLE = 8'h00;
	localparam logic [7:0] OFF_TRG_CFG_ONE = 8'h04;
	localparam logic [7:0] OFF_TRG_CFG_TWO = 8'h08;
	localparam logic [7:0] OFF_FAULT_EN = 8'h0c;
	localparam logic [7:0] OFF_FAULT_VALUE = 8'h10;
	localparam logic [7:0] OFF_SYNC_CHAN = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_WRITE_GUARD = 8'he4;

	// Field positions
	localparam int TRG_MODE_LSB = 0;
	localparam int TRG_RECOVERABLE_FAULT_ENABLE_BIT = 2;
	localparam int FPE_F2_LSB = 8;
	localparam int FPV_LOW_LSB = 16;
	localparam int STAT_FORCE_LSB = 8;
	localparam int STAT_PROT_LSB = 16;
	localparam int STAT_HWPROT_LSB = 24;
	localparam int WG_CMD_LSB = 0;
	localparam int WG_GRP_LSB = 2;
	localparam int WG_KEY_LSB = 8;

	// Key that unlocks a guard command
	localparam logic [23:0] GUARD_KEY = 24'h50574d;

	// Register groups that the guard can lock
	localparam int NGRP = 6;
	localparam int GRP_CHAN = 0;
	localparam int GRP_TRG = 1;
	localparam int GRP_FPE = 2;
	localparam int GRP_FPV = 3;
	localparam int GRP_SYNC = 4;

	// Guard commands
	localparam logic [1:0] CMD_UNLOCK = 2'h0;
	localparam logic [1:0] CMD_LOCK_SW = 2'h1;
	localparam logic [1:0] CMD_LOCK_HW = 2'h2;

	// Trigger behaviour codes
	localparam logic [1:0] TRG_OFF = 2'h0;
	localparam logic [1:0] TRG_RISE = 2'h1;
	localparam logic [1:0] TRG_FALL = 2'h2;
	localparam logic [1:0] TRG_BOTH = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	typedef struct packed {
		logic recoverable_fault_enable;
		logic [1:0] trigger_behaviour_select;
	} pwmrf_trg_cfg_t;
endpackage : pwmrf_pkg

/* pwmrf_guard.sv */
// Recoverable-fault forcing for faults 1 and 2 and the keyed write guard of the modulator.
// Assumes counters, waveform generation and the classic fault path live outside and
// supply per-channel period-end pulses and raw high/low waveforms on this clock.
`timescale 1ns/1ns
`default_nettype none

module pwmrf_guard #(
	parameter int NCH = 4
) (
	input wire logic clk, // 125 MHz peripheral clock
	input wire logic reset, // Asynchronous, active high
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic ext_trigger_input_one, // Trigger pin for fault 1
	input wire logic ext_trigger_input_two, // Trigger pin for fault 2
	input wire logic [2:0] fault_pin, // Raw fault pins 0..2
	input wire logic [NCH-1:0] period_end, // Per-channel end of period pulse
	input wire logic [NCH-1:0] wave_high_in, // Unforced high-side waveform
	input wire logic [NCH-1:0] wave_low_in, // Unforced low-side waveform
	output logic [NCH-1:0] pwm_high_out, // High-side output after forcing
	output logic [NCH-1:0] pwm_low_out, // Low-side output after forcing
	output logic [NCH-1:0] channel_enable, // Channel enables to the counters
	output logic [2:0] classic_fault // Synchronised fault pins for the classic path
);
	// Configuration and state
	logic [NCH-1:0] chen_q;
	pwmrf_pkg::pwmrf_trg_cfg_t trg1_q, trg2_q;
	logic [NCH-1:0] fpe1_q, fpe2_q;
	logic [NCH-1:0] fpvh_q, fpvl_q;
	logic [NCH-1:0] sync_q;
	logic [2:0] fstat_q;
	logic [pwmrf_pkg::NGRP-1:0] prot_sw_q, prot_hw_q;
	logic [NCH-1:0] force_q, force_d;
	logic [NCH-1:0] pwmh_q, pwml_q;
	logic [2:0] classic_q;

	// Synchronisers
	logic [1:0] trg_s1_q, trg_s2_q, trg_s3_q;
	logic [2:0] fp_s1_q, fp_s2_q;

	// Bus slave state
	logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;

	function automatic logic [31:0] pwmrf_merge(input logic [31:0] old_w, input logic [31:0] new_w,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return res;
	endfunction : pwmrf_merge

	// Mode 0 detects nothing, so a zero mode can never raise a fault
	function automatic logic pwmrf_event(input logic [1:0] mode, input logic rise,
			input logic fall);
		return (mode == pwmrf_pkg::TRG_RISE && rise) || (mode == pwmrf_pkg::TRG_FALL && fall)
			|| (mode == pwmrf_pkg::TRG_BOTH && (rise || fall));
	endfunction : pwmrf_event

	// Trigger edges, seen only on synchronised samples
	wire [1:0] trg_rise = trg_s2_q & ~trg_s3_q;
	wire [1:0] trg_fall = ~trg_s2_q & trg_s3_q;

	wire rf_cfg1 = trg1_q.recoverable_fault_enable && chen_q[1]
		&& trg1_q.trigger_behaviour_select != pwmrf_pkg::TRG_OFF;
	wire rf_cfg2 = trg2_q.recoverable_fault_enable && chen_q[2]
		&& trg2_q.trigger_behaviour_select != pwmrf_pkg::TRG_OFF;
	wire [2:0] rf_cfg = {rf_cfg2, rf_cfg1, 1'b0};

	wire rf_fault1 = rf_cfg1 && pwmrf_event(trg1_q.trigger_behaviour_select,
		trg_rise[0], trg_fall[0]);
	wire rf_fault2 = rf_cfg2 && pwmrf_event(trg2_q.trigger_behaviour_select,
		trg_rise[1], trg_fall[1]);

	// Pins of recoverable faults are masked before the classic path sees them
	wire [2:0] classic_d = fp_s2_q & ~rf_cfg;

	logic [NCH-1:0] hit;
	always_comb begin
		for (int x = 0; x < NCH; x++) begin
			// Synchronous channels borrow the channel 0 enables
			hit[x] = (rf_fault1 && (sync_q[x] ? fpe1_q[0] : fpe1_q[x]))
				|| (rf_fault2 && (sync_q[x] ? fpe2_q[0] : fpe2_q[x]));
			// A fresh event holds forcing even if it lands on a period end
			force_d[x] = hit[x] || (force_q[x] && !period_end[x]);
		end
	end

	// Bus handshakes
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready = !w_full_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	wire aw_take = s_axi_awvalid && !aw_full_q;
	wire w_take = s_axi_wvalid && !w_full_q;
	wire ar_take = s_axi_arvalid && !rvalid_q;
	wire wr_go = aw_full_q && w_full_q && !bvalid_q;

	wire [pwmrf_pkg::NGRP-1:0] locked = prot_sw_q | prot_hw_q;

	// Write decode
	wire sel_chen = wr_go && awaddr_q == pwmrf_pkg::OFF_CHAN_ENABLE;
	wire sel_trg1 = wr_go && awaddr_q == pwmrf_pkg::OFF_TRG_CFG_ONE;
	wire sel_trg2 = wr_go && awaddr_q == pwmrf_pkg::OFF_TRG_CFG_TWO;
	wire sel_fpe = wr_go && awaddr_q == pwmrf_pkg::OFF_FAULT_EN;
	wire sel_fpv = wr_go && awaddr_q == pwmrf_pkg::OFF_FAULT_VALUE;
	wire sel_sync = wr_go && awaddr_q == pwmrf_pkg::OFF_SYNC_CHAN;
	wire sel_stat = wr_go && awaddr_q == pwmrf_pkg::OFF_STATUS;
	wire sel_guard = wr_go && awaddr_q == pwmrf_pkg::OFF_WRITE_GUARD;
	wire wr_mapped = sel_chen || sel_trg1 || sel_trg2 || sel_fpe || sel_fpv || sel_sync
		|| sel_stat || sel_guard;

	// Each configuration register's word with the strobed bytes merged in
	wire [31:0] m_chen = pwmrf_merge(32'(chen_q), wdata_q, wstrb_q);
	wire [31:0] m_trg1 = pwmrf_merge(32'(trg1_q), wdata_q, wstrb_q);
	wire [31:0] m_trg2 = pwmrf_merge(32'(trg2_q), wdata_q, wstrb_q);
	wire [31:0] m_fpe = pwmrf_merge((32'(fpe2_q) << pwmrf_pkg::FPE_F2_LSB) | 32'(fpe1_q),
		wdata_q, wstrb_q);
	wire [31:0] m_fpv = pwmrf_merge((32'(fpvl_q) << pwmrf_pkg::FPV_LOW_LSB) | 32'(fpvh_q),
		wdata_q, wstrb_q);
	wire [31:0] m_sync = pwmrf_merge(32'(sync_q), wdata_q, wstrb_q);

	wire wr_chen = sel_chen && !locked[pwmrf_pkg::GRP_CHAN];
	wire wr_trg1 = sel_trg1 && !locked[pwmrf_pkg::GRP_TRG];
	wire wr_trg2 = sel_trg2 && !locked[pwmrf_pkg::GRP_TRG];
	wire wr_fpe = sel_fpe && !locked[pwmrf_pkg::GRP_FPE];
	wire wr_fpv = sel_fpv && !locked[pwmrf_pkg::GRP_FPV];
	wire wr_sync = sel_sync && !locked[pwmrf_pkg::GRP_SYNC];

	// Guard command; a write without all four byte strobes is dropped, even one that carries the whole key
	wire [23:0] g_key = wdata_q[pwmrf_pkg::WG_KEY_LSB +: 24];
	wire [1:0] g_cmd = wdata_q[pwmrf_pkg::WG_CMD_LSB +: 2];
	wire [pwmrf_pkg::NGRP-1:0] g_grp = wdata_q[pwmrf_pkg::WG_GRP_LSB +: pwmrf_pkg::NGRP];
	wire g_ok = sel_guard && wstrb_q == 4'hf && g_key == pwmrf_pkg::GUARD_KEY;
	wire [pwmrf_pkg::NGRP-1:0] g_sel = g_ok ? g_grp : '0;
	wire [pwmrf_pkg::NGRP-1:0] prot_sw_d = (g_cmd == pwmrf_pkg::CMD_UNLOCK) ? prot_sw_q & ~g_sel
		: (g_cmd == pwmrf_pkg::CMD_LOCK_SW) ? prot_sw_q | g_sel : prot_sw_q;
	// Hardware locks are released only by reset
	wire [pwmrf_pkg::NGRP-1:0] prot_hw_d = (g_cmd == pwmrf_pkg::CMD_LOCK_HW)
		? prot_hw_q | g_sel : prot_hw_q;

	// Status: write one to clear, a new fault in the same cycle wins
	wire [2:0] fstat_clr = (sel_stat && wstrb_q[0]) ? wdata_q[2:0] : 3'h0;
	wire [2:0] fstat_d = classic_d | (fstat_q & ~fstat_clr);

	// Read decode
	logic [31:0] rd_word;
	logic rd_err;
	always_comb begin
		rd_word = pwmrf_pkg::ZERO_WORD;
		rd_err = 1'b0;
		if (s_axi_araddr == pwmrf_pkg::OFF_CHAN_ENABLE) begin
			rd_word = 32'(chen_q);
		end else if (s_axi_araddr == pwmrf_pkg::OFF_TRG_CFG_ONE) begin
			rd_word = 32'(trg1_q);
		end else if (s_axi_araddr == pwmrf_pkg::OFF_TRG_CFG_TWO) begin
			rd_word = 32'(trg2_q);
		end else if (s_axi_araddr == pwmrf_pkg::OFF_FAULT_EN) begin
			rd_word = (32'(fpe2_q) << pwmrf_pkg::FPE_F2_LSB) | 32'(fpe1_q);
		end else if (s_axi_araddr == pwmrf_pkg::OFF_FAULT_VALUE) begin
			rd_word = (32'(fpvl_q) << pwmrf_pkg::FPV_LOW_LSB) | 32'(fpvh_q);
		end else if (s_axi_araddr == pwmrf_pkg::OFF_SYNC_CHAN) begin
			rd_word = 32'(sync_q);
		end else if (s_axi_araddr == pwmrf_pkg::OFF_STATUS) begin
			rd_word = 32'(fstat_q) | (32'(force_q) << pwmrf_pkg::STAT_FORCE_LSB)
				| (32'(prot_sw_q) << pwmrf_pkg::STAT_PROT_LSB)
				| (32'(prot_hw_q) << pwmrf_pkg::STAT_HWPROT_LSB);
		end else if (s_axi_araddr == pwmrf_pkg::OFF_WRITE_GUARD) begin
			rd_word = pwmrf_pkg::ZERO_WORD;
		end else begin
			rd_err = 1'b1;
		end
	end

	// Synchronisers for pins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			trg_s1_q <= 2'h0;
			trg_s2_q <= 2'h0;
			trg_s3_q <= 2'h0;
			fp_s1_q <= 3'h0;
			fp_s2_q <= 3'h0;
		end else begin
			trg_s1_q <= {ext_trigger_input_two, ext_trigger_input_one};
			trg_s2_q <= trg_s1_q;
			trg_s3_q <= trg_s2_q;
			fp_s1_q <= fault_pin;
			fp_s2_q <= fp_s1_q;
		end
	end

	// Forcing and outputs; counters are never touched from here
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			force_q <= '0;
			pwmh_q <= '0;
			pwml_q <= '0;
			classic_q <= 3'h0;
			fstat_q <= 3'h0;
		end else begin
			force_q <= force_d;
			pwmh_q <= (force_d & fpvh_q) | (~force_d & wave_high_in);
			pwml_q <= (force_d & fpvl_q) | (~force_d & wave_low_in);
			classic_q <= classic_d;
			fstat_q <= fstat_d;
		end
	end

	assign pwm_high_out = pwmh_q;
	assign pwm_low_out = pwml_q;
	assign channel_enable = chen_q;
	assign classic_fault = classic_q;

	// Configuration registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			chen_q <= '0;
			trg1_q <= '0;
			trg2_q <= '0;
			fpe1_q <= '0;
			fpe2_q <= '0;
			fpvh_q <= '0;
			fpvl_q <= '0;
			sync_q <= '0;
			prot_sw_q <= '0;
			prot_hw_q <= '0;
		end else begin
			if (wr_chen) begin
				chen_q <= m_chen[NCH-1:0];
			end
			if (wr_trg1) begin
				trg1_q <= m_trg1[2:0];
			end
			if (wr_trg2) begin
				trg2_q <= m_trg2[2:0];
			end
			if (wr_fpe) begin
				fpe1_q <= m_fpe[NCH-1:0];
				fpe2_q <= m_fpe[pwmrf_pkg::FPE_F2_LSB +: NCH];
			end
			if (wr_fpv) begin
				fpvh_q <= m_fpv[NCH-1:0];
				fpvl_q <= m_fpv[pwmrf_pkg::FPV_LOW_LSB +: NCH];
			end
			if (wr_sync) begin
				sync_q <= m_sync[NCH-1:0];
			end
			prot_sw_q <= prot_sw_d;
			prot_hw_q <= prot_hw_d;
		end
	end

	// Bus slave: address and data are taken in either order, one write in flight
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			bvalid_q <= 1'b0;
			rvalid_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= pwmrf_pkg::ZERO_WORD;
			wstrb_q <= 4'h0;
			bresp_q <= pwmrf_pkg::RESP_OKAY;
			rresp_q <= pwmrf_pkg::RESP_OKAY;
			rdata_q <= pwmrf_pkg::ZERO_WORD;
		end else begin
			if (aw_take) begin
				aw_full_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_full_q <= 1'b0;
			end
			if (w_take) begin
				w_full_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (wr_go) begin
				w_full_q <= 1'b0;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_mapped ? pwmrf_pkg::RESP_OKAY : pwmrf_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (ar_take) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= rd_err ? pwmrf_pkg::RESP_SLVERR : pwmrf_pkg::RESP_OKAY;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end
endmodule : pwmrf_guard

`default_nettype wire

/* pwmrf_sva.sv */
// Checker for the recoverable-fault and write-guard block, on its top ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module pwmrf_sva #(
	parameter int NCH = 4
) (
	input wire logic clk, // Clock
	input wire logic reset, // Reset
	input wire logic [7:0] s_axi_awaddr, // Bus
	input wire logic s_axi_awvalid, // Bus
	input wire logic s_axi_awready, // Bus
	input wire logic s_axi_wvalid, // Bus
	input wire logic s_axi_wready, // Bus
	input wire logic [1:0] s_axi_bresp, // Bus
	input wire logic s_axi_bvalid, // Bus
	input wire logic s_axi_bready, // Bus
	input wire logic s_axi_arvalid, // Bus
	input wire logic s_axi_arready, // Bus
	input wire logic [31:0] s_axi_rdata, // Bus
	input wire logic [1:0] s_axi_rresp, // Bus
	input wire logic s_axi_rvalid, // Bus
	input wire logic s_axi_rready, // Bus
	input wire logic [2:0] fault_pin, // Pins
	input wire logic [NCH-1:0] channel_enable, // Enables
	input wire logic [2:0] classic_fault // Classic path
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write response late");
	AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read dropped");
	AST_GUARD_OK: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'he4 && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] (s_axi_bvalid && s_axi_bresp == 2'h0)) else $error("guard write refused");
	AST_FAULT0: assert property ($rose(fault_pin[0]) ##1 fault_pin[0] [*4] |-> classic_fault[0])
		else $error("fault 0 not on classic path");
	AST_FAULT1: assert property (
		$rose(fault_pin[1]) ##1 (fault_pin[1] && !channel_enable[1]) [*4] |-> classic_fault[1])
		else $error("fault 1 pin ignored while not recoverable");
	AST_FAULT2: assert property (
		$rose(fault_pin[2]) ##1 (fault_pin[2] && !channel_enable[2]) [*4] |-> classic_fault[2])
		else $error("fault 2 pin ignored while not recoverable");
endmodule : pwmrf_sva
bind pwmrf_guard pwmrf_sva #(.NCH(NCH)) pwmrf_sva_i (.*);
`default_nettype wire

/* pwmrf_stage.sv */
// Far-side model: trigger sources and the power stage period and wave feed.
// Assumes the block's clock; the bench requests trigger pulses through fire.
`timescale 1ns/1ns
`default_nettype none
module pwmrf_stage #(
	parameter int NCH = 4
) (
	input wire logic clk, // Clock
	input wire logic reset, // Reset
	input wire logic [1:0] fire, // Pulse request
	output logic ext_trigger_input_one, // Trigger one
	output logic ext_trigger_input_two, // Trigger two
	output logic [NCH-1:0] period_end, // Period end
	output logic [NCH-1:0] wave_high_in, // High wave
	output logic [NCH-1:0] wave_low_in // Low wave
);
	logic [3:0] cnt_q;
	logic [1:0] t1_q;
	logic [1:0] t2_q;
	// Pulses last three cycles so the synchroniser sees both edges
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_q <= 4'h0;
			t1_q <= 2'h0;
			t2_q <= 2'h0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
			t1_q <= fire[0] ? 2'h3 : t1_q - {1'b0, |t1_q};
			t2_q <= fire[1] ? 2'h3 : t2_q - {1'b0, |t2_q};
		end
	end
	assign ext_trigger_input_one = |t1_q;
	assign ext_trigger_input_two = |t2_q;
	assign period_end = {NCH{cnt_q == 4'hf}};
	// Low is always the inverse, so both high marks forcing
	assign wave_high_in = {NCH{cnt_q[3]}};
	assign wave_low_in = ~wave_high_in;
endmodule : pwmrf_stage
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the recoverable-fault and write-guard block.
// Assumes the far-side model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, period_end, wave_high_in, wave_low_in, frc;
	logic [3:0] pwm_high_out, pwm_low_out, channel_enable;
	logic [1:0] s_axi_bresp, s_axi_rresp, fire;
	logic [2:0] fault_pin, classic_fault;
	logic ext_trigger_input_one, ext_trigger_input_two;
	int fails, check_count;
	pwmrf_guard pwmrf_guard_i (.*);
	pwmrf_stage pwmrf_stage_i (.*);
	assign frc = pwm_high_out & pwm_low_out;
	task automatic report_and_stop;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop
	task automatic spin(inout int n);
		n++;
		if (n > 60) begin
			fails++;
			report_and_stop();
		end
	endtask : spin
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("MISMATCH %s exp %h got %h", nm, e, g);
			fails++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw;
		int n;
		ta = 1'b0;
		tw = 1'b0;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge clk);
			ta = ta | s_axi_awready;
			tw = tw | s_axi_wready;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			spin(n);
		end
		while (s_axi_bvalid !== 1'b1) begin
			@(negedge clk);
			spin(n);
		end
		@(posedge clk);
		s_axi_bready <= 1'b1;
		@(negedge clk);
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(negedge clk);
			spin(n);
		end while (s_axi_arready !== 1'b1);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge clk);
			spin(n);
		end while (s_axi_rvalid !== 1'b1);
		chk("rdata", e, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		@(posedge clk);
		s_axi_rready <= 1'b1;
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask : rd
	// Watches long enough for the slowest event plus one whole period of the stage model
	task automatic pulse(input logic [1:0] f, input logic [3:0] e);
		logic [3:0] seen, prev;
		logic pe;
		seen = 4'h0;
		prev = 4'h0;
		pe = 1'b0;
		@(posedge clk);
		fire <= f;
		@(posedge clk);
		fire <= 2'h0;
		repeat (40) begin
			@(negedge clk);
			if (prev !== 4'h0 && frc === 4'h0) begin
				chk("release_after_period_end", 32'h1, {31'h0, pe});
			end
			seen = seen | frc;
			prev = frc;
			pe = period_end[0];
		end
		chk("forced", {28'h0, e}, {28'h0, seen});
		chk("released", 32'h0, {28'h0, frc});
	endtask : pulse
	task automatic t_recov;
		wr(8'h00, 32'hf, 2'h0);
		wr(8'h0c, 32'h40a, 2'h0);
		wr(8'h10, 32'hf000f, 2'h0);
		wr(8'h14, 32'h8, 2'h0);
		wr(8'h08, 32'h5, 2'h0);
		for (int m = 0; m < 4; m++) begin
			wr(8'h04, {30'h1, m[1:0]}, 2'h0);
			pulse(2'h1, m == 0 ? 4'h0 : 4'h2);
		end
		pulse(2'h2, 4'h4);
		wr(8'h0c, 32'h1, 2'h0);
		pulse(2'h1, 4'h9);
		wr(8'h04, 32'h1, 2'h0);
		pulse(2'h1, 4'h0);
		wr(8'h04, 32'h5, 2'h0);
		wr(8'h00, 32'h4, 2'h0);
		pulse(2'h1, 4'h0);
	endtask : t_recov
	task automatic t_pins(input logic [31:0] ce, input logic [31:0] e);
		wr(8'h00, ce, 2'h0);
		@(posedge clk);
		fault_pin <= 3'h7;
		repeat (8) @(posedge clk);
		@(negedge clk);
		chk("classic", e, {29'h0, classic_fault});
		rd(8'h18, e, 2'h0);
		fault_pin <= 3'h0;
		repeat (8) @(posedge clk);
		wr(8'h18, 32'h7, 2'h0);
		rd(8'h18, 32'h0, 2'h0);
	endtask : t_pins
	task automatic t_guard;
		wr(8'he4, 32'h50574c05, 2'h0);
		wr(8'h00, 32'h1, 2'h0);
		rd(8'h00, 32'h1, 2'h0);
		wr(8'he4, 32'h50574d05, 2'h0);
		wr(8'h00, 32'h6, 2'h0);
		rd(8'h00, 32'h1, 2'h0);
		wr(8'h04, 32'h6, 2'h0);
		rd(8'h04, 32'h6, 2'h0);
		rd(8'h18, 32'h10000, 2'h0);
		rd(8'he4, 32'h0, 2'h0);
		wr(8'hf0, 32'h1, 2'h2);
		rd(8'hf0, 32'h0, 2'h2);
		wr(8'he4, 32'h50574d07, 2'h0);
		rd(8'h18, 32'h10000, 2'h0);
		wr(8'he4, 32'h50574d04, 2'h0);
		wr(8'h00, 32'h6, 2'h0);
		rd(8'h00, 32'h6, 2'h0);
		chk("channel_enable", 32'h6, {28'h0, channel_enable});
		wr(8'he4, 32'h50574d86, 2'h0);
		rd(8'h18, 32'h21000000, 2'h0);
		wr(8'he4, 32'h50574d84, 2'h0);
		wr(8'h00, 32'h1, 2'h0);
		rd(8'h00, 32'h6, 2'h0);
		rd(8'h18, 32'h21000000, 2'h0);
	endtask : t_guard
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		reset = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = 8'h0;
		s_axi_araddr = 8'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		fault_pin = 3'h0;
		fire = 2'h0;
		fails = 0;
		check_count = 0;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		t_recov();
		t_pins(32'h6, 32'h1);
		t_pins(32'h0, 32'h7);
		t_guard();
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
